/* File: logic/okd_regs.svh */
`ifndef OKD_REGS_SVH
`define OKD_REGS_SVH
// Register byte offsets.
`define OKD_CTRL_OFS 8'h00
`define OKD_STATUS_OFS 8'h04
`define OKD_PENDING_OFS 8'h08
`define OKD_COMMIT_OFS 8'h0c
// Field positions and reset values.
`define OKD_CTRL_HEADINGS_BIT 0
`define OKD_CTRL_RESET 32'h0000_0001
`define OKD_ST_PEND_BIT 4
`define OKD_ST_NACK_BIT 5
`define OKD_ST_WAIT_BIT 6
`define OKD_ST_GROUP_LSB 8
`define OKD_ST_ITEM_LSB 12
// Timing in its own units, and the clock rate.
`define OKD_CLK_KHZ 10000
`define OKD_DEBOUNCE_MS 20
`define OKD_HOLD_MS 500
`define OKD_REPEAT_MS 100
`define OKD_COARSE_MS 2000
`define OKD_REFRESH_MS 2000
`define OKD_WARN_MS 5000
`define OKD_PANIC_MS 2000
`define OKD_BLANK_MS 100
`define OKD_NACK_MS 30000
`define OKD_BLINK_MS 500
`define OKD_SCAN_CYC 16
// Keypad matrix, index is row times four plus column.
`define OKD_KEY_CHILLER 4'h1
`define OKD_KEY_PREV 4'h8
`define OKD_KEY_PLUS 4'h9
`define OKD_KEY_ENTER 4'ha
`define OKD_KEY_AUTO 4'hb
`define OKD_KEY_NEXT 4'hc
`define OKD_KEY_MINUS 4'hd
`define OKD_KEY_CANCEL 4'he
`define OKD_KEY_STOP 4'hf
// Edit steps.
`define OKD_STEP_FINE 16'h0001
`define OKD_STEP_COARSE 16'h000a
`endif

/* File: logic/okd_pkg.sv */
package okd_pkg;
   typedef enum logic [3:0] {
      OKD_BROWSE = 4'b0001,
      OKD_WARN = 4'b0010,
      OKD_PANIC = 4'b0100,
      OKD_BLANK = 4'b1000
   } okd_state_type;

   typedef enum logic [2:0] {
      OKD_SCR_ITEM = 3'h0,
      OKD_SCR_HEADER = 3'h1,
      OKD_SCR_STOP_WARN = 3'h2,
      OKD_SCR_PANIC = 3'h3,
      OKD_SCR_NACK = 3'h4
   } okd_screen_type;

   // Screen descriptor for the two-line, forty-character text panel.
   typedef struct packed {
      logic blank;
      okd_screen_type screen;
      logic [2:0] group;
      logic [3:0] item;
      logic pending;
      logic [15:0] value;
   } okd_disp_type;

   // Commands and setting commits to the chiller module.
   typedef struct packed {
      logic stop;
      logic panic;
      logic auto_run;
      logic commit;
      logic [2:0] group;
      logic [3:0] item;
      logic [15:0] value;
   } okd_cmd_type;
endpackage

/* File: logic/okd_panel.sv */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "okd_regs.svh"
// How it works
// RULE1 - Red alarm indicator blinks while a latching diagnostic is present.
// RULE2 - With manual override and no diagnostic, the red indicator is lit steadily.
// RULE3 - Diagnostic together with override blinks; blinking wins over steady.
// RULE4 - Sixteen keys scanned as a four by four matrix.
// RULE5 - Screens are for a two-line, forty-character text panel.
// RULE6 - A shown report item is refreshed about every two seconds.
// RULE7 - Group key shows the header, or the first item when headings are off.
// RULE8 - Next and Previous step through items and wrap within the group.
// RULE9 - Single plus or minus press changes the pending value by one step.
// RULE10 - Held beyond half a second, the change repeats ten times per second.
// RULE11 - Held two seconds, each repeat step is ten times the normal step.
// RULE12 - Edited value stays pending and shown; Enter commits it.
// RULE13 - Cancel drops the pending value and leaves the stored setting.
// RULE14 - After Enter the display blanks briefly.
// RULE15 - Stop and Auto act at once, with no Enter.
// RULE16 - First Stop shows the panic warning for five seconds and opens a window.
// RULE17 - Second Stop inside the window issues an immediate panic stop.
// RULE18 - Panic message shows two seconds, then the first chiller screen.
// RULE19 - Without second Stop, unload runs on and the first chiller screen shows.
// RULE20 - Auto while stopped commands automatic operation.
// RULE21 - Any Auto or Stop goes to the first chiller report screen; Auto is ignored in panic, Stop in blank and panic.
// RULE22 - Committed settings are stored by the chiller module, not here.
// RULE23 - Commit unacknowledged for thirty quiet seconds adds a notice to the chiller report.
// RULE24 - Keys are debounced and give one press event per closure.
module okd_panel
   import okd_pkg::*;
#(
   parameter int unsigned ITEMS = 8,
   parameter int unsigned DEB_CYC = `OKD_DEBOUNCE_MS * `OKD_CLK_KHZ,
   parameter int unsigned HOLD_CYC = `OKD_HOLD_MS * `OKD_CLK_KHZ,
   parameter int unsigned REP_CYC = `OKD_REPEAT_MS * `OKD_CLK_KHZ,
   parameter int unsigned COARSE_CYC = `OKD_COARSE_MS * `OKD_CLK_KHZ,
   parameter int unsigned REFRESH_CYC = `OKD_REFRESH_MS * `OKD_CLK_KHZ,
   parameter int unsigned WARN_CYC = `OKD_WARN_MS * `OKD_CLK_KHZ,
   parameter int unsigned PANIC_CYC = `OKD_PANIC_MS * `OKD_CLK_KHZ,
   parameter int unsigned BLANK_CYC = `OKD_BLANK_MS * `OKD_CLK_KHZ,
   parameter int unsigned NACK_CYC = `OKD_NACK_MS * `OKD_CLK_KHZ,
   parameter int unsigned BLINK_CYC = `OKD_BLINK_MS * `OKD_CLK_KHZ
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Keypad matrix, rows driven low one at a time, columns read low when closed.
   output logic [3:0] key_row_n,
   input wire logic [3:0] key_col_n,
   // Text panel and alarm indicator.
   output okd_disp_type disp,
   output logic disp_refresh,
   output logic alarm_led,
   // Chiller control module.
   input wire logic diag_latched,
   input wire logic manual_override,
   input wire logic chiller_stopped,
   input wire logic set_ack,
   input wire logic [15:0] set_value_in,
   output okd_cmd_type cmd
);
   logic [1:0] row_reg;
   logic [7:0] scan_cnt_reg;
   logic [15:0] raw_map_reg, last_map_reg, stable_map_reg, prev_map_reg;
   logic [31:0] deb_cnt_reg, hold_cnt_reg, rep_cnt_reg, msg_cnt_reg, ref_cnt_reg, nack_cnt_reg, blink_cnt_reg;
   logic [3:0] held_key_reg;
   logic press_valid, rep_step, step_evt, step_up, edit_ok, nav_clr, at_nack;
   logic [3:0] press_key;
   logic [15:0] new_press, step_size, edit_base;
   okd_state_type state_reg;
   logic [2:0] group_reg;
   logic [3:0] item_reg, first_item, last_item;
   logic pending_reg, waiting_reg, nack_reg, blink_reg;
   logic [15:0] pending_val_reg, commit_val_reg;
   logic [31:0] ctrl_reg, rd_mux;
   logic dp_write_reg;
   logic [7:0] dp_addr_reg;

   // Row scan: each row is driven for a fixed slot, columns sampled at its end.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_reg <= 2'h0;
         scan_cnt_reg <= 8'h00;
         key_row_n <= 4'he;
         raw_map_reg <= 16'h0000;
      end else if (scan_cnt_reg == 8'(`OKD_SCAN_CYC - 1)) begin
         scan_cnt_reg <= 8'h00;
         raw_map_reg[row_reg*4 +: 4] <= ~key_col_n; // RULE4
         row_reg <= row_reg + 2'h1;
         key_row_n <= ~(4'h1 << (row_reg + 2'h1));
      end else begin
         scan_cnt_reg <= scan_cnt_reg + 8'h01;
      end
   end

   // The whole map must hold still for the debounce time.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_map_reg <= 16'h0000;
         stable_map_reg <= 16'h0000;
         prev_map_reg <= 16'h0000;
         deb_cnt_reg <= 32'h0;
      end else begin
         prev_map_reg <= stable_map_reg;
         if (raw_map_reg != last_map_reg) begin
            last_map_reg <= raw_map_reg;
            deb_cnt_reg <= 32'h0;
         end else if (deb_cnt_reg >= DEB_CYC - 1) begin
            stable_map_reg <= last_map_reg; // RULE24
         end else begin
            deb_cnt_reg <= deb_cnt_reg + 32'h1;
         end
      end
   end

   // One event per new closure; of keys closing together only the lowest counts.
   always_comb begin
      new_press = stable_map_reg & ~prev_map_reg; // RULE24
      press_valid = |new_press;
      press_key = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (new_press[i]) begin
            press_key = 4'(i);
         end
      end
   end

   // Hold time of the last key drives auto-repeat and the coarse step.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         held_key_reg <= 4'h0;
         hold_cnt_reg <= 32'h0;
         rep_cnt_reg <= 32'h0;
      end else if (press_valid) begin
         held_key_reg <= press_key;
         hold_cnt_reg <= 32'h0;
         rep_cnt_reg <= 32'h0;
      end else if (stable_map_reg[held_key_reg]) begin
         if (hold_cnt_reg < COARSE_CYC) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
         end
         if (hold_cnt_reg >= HOLD_CYC) begin
            rep_cnt_reg <= (rep_cnt_reg >= REP_CYC - 1) ? 32'h0 : rep_cnt_reg + 32'h1; // RULE10
         end
      end else begin
         hold_cnt_reg <= 32'h0;
         rep_cnt_reg <= 32'h0;
      end
   end

   // Step requests from a fresh press or from a repeat tick.
   always_comb begin
      rep_step = stable_map_reg[held_key_reg] && !press_valid && hold_cnt_reg >= HOLD_CYC &&
                 rep_cnt_reg >= REP_CYC - 1 &&
                 (held_key_reg == `OKD_KEY_PLUS || held_key_reg == `OKD_KEY_MINUS); // RULE10
      step_up = press_valid ? (press_key == `OKD_KEY_PLUS) : (held_key_reg == `OKD_KEY_PLUS);
      step_evt = rep_step || (press_valid && (press_key == `OKD_KEY_PLUS || press_key == `OKD_KEY_MINUS)); // RULE9
      step_size = (rep_step && hold_cnt_reg >= COARSE_CYC) ? `OKD_STEP_COARSE : `OKD_STEP_FINE; // RULE11
      edit_ok = state_reg == OKD_BROWSE && group_reg[2] && item_reg != 4'h0;
      edit_base = pending_reg ? pending_val_reg : set_value_in;
      first_item = ctrl_reg[`OKD_CTRL_HEADINGS_BIT] ? 4'h0 : 4'h1; // RULE7
      at_nack = group_reg == `OKD_KEY_CHILLER && nack_reg;
      last_item = at_nack ? 4'(ITEMS + 1) : 4'(ITEMS); // RULE23
      nav_clr = state_reg == OKD_BROWSE && press_valid && at_nack && item_reg == last_item &&
                (press_key == `OKD_KEY_NEXT || press_key == `OKD_KEY_PREV);
   end

   // Navigation, edits and the Stop, Auto and Enter sequences.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= OKD_BROWSE;
         group_reg <= 3'h1;
         item_reg <= 4'h1;
         pending_reg <= 1'b0;
         pending_val_reg <= 16'h0000;
         commit_val_reg <= 16'h0000;
         msg_cnt_reg <= 32'h0;
         cmd <= '0;
      end else begin
         cmd.stop <= 1'b0;
         cmd.panic <= 1'b0;
         cmd.auto_run <= 1'b0;
         cmd.commit <= 1'b0;
         msg_cnt_reg <= msg_cnt_reg + 32'h1;
         if (press_valid && press_key == `OKD_KEY_AUTO && state_reg != OKD_PANIC) begin
            cmd.auto_run <= chiller_stopped; // RULE20 RULE15
            state_reg <= OKD_BROWSE;
            group_reg <= 3'(`OKD_KEY_CHILLER); // RULE21
            item_reg <= 4'h1;
            pending_reg <= 1'b0;
         end else begin
            case (state_reg)
               OKD_BROWSE: begin
                  if (press_valid) begin
                     if (press_key < 4'h8) begin
                        group_reg <= press_key[2:0]; // RULE7
                        item_reg <= first_item;
                        pending_reg <= 1'b0;
                     end else if (press_key == `OKD_KEY_NEXT) begin
                        item_reg <= (item_reg >= last_item) ? first_item : item_reg + 4'h1; // RULE8
                        pending_reg <= 1'b0;
                     end else if (press_key == `OKD_KEY_PREV) begin
                        item_reg <= (item_reg <= first_item) ? last_item : item_reg - 4'h1; // RULE8
                        pending_reg <= 1'b0;
                     end else if (press_key == `OKD_KEY_ENTER) begin
                        state_reg <= OKD_BLANK; // RULE14
                        msg_cnt_reg <= 32'h0;
                        if (pending_reg) begin
                           cmd.commit <= 1'b1; // RULE12 RULE22
                           cmd.group <= group_reg;
                           cmd.item <= item_reg;
                           cmd.value <= pending_val_reg;
                           commit_val_reg <= pending_val_reg;
                           pending_reg <= 1'b0;
                        end
                     end else if (press_key == `OKD_KEY_CANCEL) begin
                        pending_reg <= 1'b0; // RULE13
                     end else if (press_key == `OKD_KEY_STOP) begin
                        cmd.stop <= 1'b1; // RULE15
                        state_reg <= OKD_WARN; // RULE16
                        msg_cnt_reg <= 32'h0;
                        group_reg <= 3'(`OKD_KEY_CHILLER); // RULE21
                        item_reg <= 4'h1;
                        pending_reg <= 1'b0;
                     end
                  end
                  if (step_evt && edit_ok) begin
                     pending_reg <= 1'b1; // RULE12
                     pending_val_reg <= step_up ? edit_base + step_size : edit_base - step_size; // RULE9
                  end
               end
               OKD_WARN: begin
                  if (press_valid && press_key == `OKD_KEY_STOP) begin
                     cmd.panic <= 1'b1; // RULE17
                     state_reg <= OKD_PANIC;
                     msg_cnt_reg <= 32'h0;
                  end else if (msg_cnt_reg >= WARN_CYC - 1) begin
                     state_reg <= OKD_BROWSE; // RULE19
                  end
               end
               OKD_PANIC: begin
                  if (msg_cnt_reg >= PANIC_CYC - 1) begin
                     state_reg <= OKD_BROWSE; // RULE18
                     group_reg <= 3'(`OKD_KEY_CHILLER);
                     item_reg <= 4'h1;
                  end
               end
               OKD_BLANK: begin
                  if (msg_cnt_reg >= BLANK_CYC - 1) begin
                     state_reg <= OKD_BROWSE; // RULE14
                  end
               end
               default: begin
                  state_reg <= OKD_BROWSE;
               end
            endcase
         end
      end
   end

   // Unacknowledged commit watch; a key press restarts the quiet time.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         waiting_reg <= 1'b0;
         nack_reg <= 1'b0;
         nack_cnt_reg <= 32'h0;
      end else begin
         if (cmd.commit) begin
            waiting_reg <= 1'b1;
            nack_cnt_reg <= 32'h0;
         end else if (set_ack) begin
            waiting_reg <= 1'b0;
         end else if (waiting_reg) begin
            nack_cnt_reg <= press_valid ? 32'h0 : nack_cnt_reg + 32'h1;
         end
         if (!cmd.commit && !set_ack && waiting_reg && !press_valid && nack_cnt_reg >= NACK_CYC - 1) begin
            waiting_reg <= 1'b0;
            nack_reg <= 1'b1; // RULE23
         end else if (nav_clr) begin
            nack_reg <= 1'b0;
         end
      end
   end

   // Report values are re-requested on a fixed period while a report item is shown.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cnt_reg <= 32'h0;
         disp_refresh <= 1'b0;
      end else if (state_reg == OKD_BROWSE && !group_reg[2] && item_reg != 4'h0) begin
         disp_refresh <= ref_cnt_reg >= REFRESH_CYC - 1; // RULE6
         ref_cnt_reg <= (ref_cnt_reg >= REFRESH_CYC - 1) ? 32'h0 : ref_cnt_reg + 32'h1;
      end else begin
         ref_cnt_reg <= 32'h0;
         disp_refresh <= 1'b0;
      end
   end

   // Screen descriptor; a pending value is shown in place of the stored one.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         disp <= '0;
      end else begin
         disp.blank <= state_reg == OKD_BLANK; // RULE14
         disp.group <= group_reg; // RULE5
         disp.item <= item_reg;
         disp.pending <= pending_reg;
         disp.value <= pending_reg ? pending_val_reg : set_value_in; // RULE12
         if (state_reg == OKD_WARN) begin
            disp.screen <= OKD_SCR_STOP_WARN; // RULE16
         end else if (state_reg == OKD_PANIC) begin
            disp.screen <= OKD_SCR_PANIC; // RULE18
         end else if (item_reg == 4'h0) begin
            disp.screen <= OKD_SCR_HEADER;
         end else if (at_nack && item_reg == last_item) begin
            disp.screen <= OKD_SCR_NACK; // RULE23
         end else begin
            disp.screen <= OKD_SCR_ITEM;
         end
      end
   end

   // Alarm indicator; the free-running blink keeps the flash rate steady.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blink_cnt_reg <= 32'h0;
         blink_reg <= 1'b0;
         alarm_led <= 1'b0;
      end else begin
         blink_cnt_reg <= (blink_cnt_reg >= BLINK_CYC - 1) ? 32'h0 : blink_cnt_reg + 32'h1;
         if (blink_cnt_reg >= BLINK_CYC - 1) begin
            blink_reg <= ~blink_reg;
         end
         alarm_led <= diag_latched ? blink_reg : manual_override; // RULE1 RULE2 RULE3
      end
   end

   // Read mux; a write in its data phase is forwarded to a read right behind it.
   always_comb begin
      case (haddr[7:0])
         `OKD_CTRL_OFS: rd_mux = (dp_write_reg && dp_addr_reg == `OKD_CTRL_OFS) ?
            {31'h0, hwdata[`OKD_CTRL_HEADINGS_BIT]} : ctrl_reg;
         `OKD_STATUS_OFS: begin
            rd_mux = {28'h0, state_reg};
            rd_mux[`OKD_ST_PEND_BIT] = pending_reg;
            rd_mux[`OKD_ST_NACK_BIT] = nack_reg;
            rd_mux[`OKD_ST_WAIT_BIT] = waiting_reg;
            rd_mux[`OKD_ST_GROUP_LSB +: 3] = group_reg;
            rd_mux[`OKD_ST_ITEM_LSB +: 4] = item_reg;
         end
         `OKD_PENDING_OFS: rd_mux = {16'h0000, pending_val_reg};
         `OKD_COMMIT_OFS: rd_mux = {16'h0000, commit_val_reg};
         default: rd_mux = 32'h0;
      endcase
   end

   // Zero-wait AHB-Lite slave; only the control word is writable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         ctrl_reg <= `OKD_CTRL_RESET;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (dp_write_reg && dp_addr_reg == `OKD_CTRL_OFS) begin
            ctrl_reg <= {31'h0, hwdata[`OKD_CTRL_HEADINGS_BIT]};
         end
         if (hsel && htrans[1] && hready) begin
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
            if (!hwrite) begin
               hrdata <= rd_mux;
            end
         end else begin
            dp_write_reg <= 1'b0;
         end
      end
   end
endmodule // okd_panel

/* File: verif/okd_far_model.sv */
`timescale 1ns/1ps
// Far side: key matrix and the chiller module's setting store.
module okd_far_model
   import okd_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Key matrix.
   input wire logic [3:0] key_row_n,
   output logic [3:0] key_col_n,
   input wire logic down,
   input wire logic [3:0] idx,
   // Setting store.
   input wire okd_cmd_type cmd,
   input wire logic [15:0] base,
   output logic [15:0] set_value_in
);
   logic has_reg;
   logic [15:0] val_reg;

   // Open columns rest at the pull-up level; a closed key shows only in its driven row.
   always_comb begin
      key_col_n = 4'hf;
      if (down && !key_row_n[idx[3:2]]) begin
         key_col_n[idx[1:0]] = 1'b0;
      end
   end

   // Base value until a commit replaces it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         has_reg <= 1'b0;
         val_reg <= 16'h0000;
      end else if (cmd.commit) begin
         has_reg <= 1'b1;
         val_reg <= cmd.value;
      end
   end
   assign set_value_in = has_reg ? val_reg : base;
endmodule // okd_far_model

/* File: verif/okd_panel_props.sv */
`timescale 1ns/1ps
// Port-level checks of the operator panel.
module okd_panel_props
   import okd_pkg::*;
#(
   parameter int unsigned BLINK_CYC = 20
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Observed ports.
   input wire logic [3:0] key_row_n,
   input wire okd_disp_type disp,
   input wire logic disp_refresh,
   input wire logic alarm_led,
   input wire logic diag_latched,
   input wire logic manual_override,
   input wire okd_cmd_type cmd
);
   int unsigned blink_cnt;
   logic led_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Cycles the lamp holds one level under a diagnostic.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blink_cnt <= 0;
         led_q <= 1'b0;
      end else begin
         led_q <= alarm_led;
         blink_cnt <= (!diag_latched || alarm_led != led_q) ? 0 : blink_cnt + 1;
      end
   end

   chk_row_single: assert property ($onehot(~key_row_n))
      else $error("not exactly one key row driven");
   chk_row_hold: assert property ($changed(key_row_n) |=> $stable(key_row_n)[*8])
      else $error("key row slot too short");
   chk_alarm_steady: assert property ((!diag_latched && manual_override)[*2] |-> alarm_led)
      else $error("override lamp not steady on");
   chk_alarm_dark: assert property ((!diag_latched && !manual_override)[*2] |-> !alarm_led)
      else $error("lamp lit with no cause");
   chk_blink_runs: assert property (blink_cnt <= BLINK_CYC + 3)
      else $error("lamp not blinking under diagnostic");
   chk_stop_pulse: assert property (cmd.stop |=> !cmd.stop)
      else $error("stop command longer than one cycle");
   chk_panic_msg: assert property ($rose(cmd.panic) |-> ##[0:2] disp.screen == OKD_SCR_PANIC)
      else $error("panic message missing");
   chk_refresh_item: assert property (disp_refresh |->
      (disp.group < 3'h4 && disp.item != 4'h0) || ($past(disp.group) < 3'h4 && $past(disp.item) != 4'h0))
      else $error("refresh outside a report item");
   chk_enter_blank: assert property (cmd.commit |-> ##[0:2] disp.blank)
      else $error("no blank after enter");

   cov_stop: cover property (cmd.stop);
   cov_panic: cover property (cmd.panic);
   cov_auto: cover property (cmd.auto_run);
   cov_commit: cover property (cmd.commit);
endmodule // okd_panel_props

/* File: verif/okd_panel_tb.sv */
`timescale 1ns/1ps
module okd_panel_tb;
   import okd_pkg::*;
   localparam int ITEMS = 3;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, kdown, diag, ovr, stopped, ack, hreadyout, hresp, disp_refresh, alarm_led;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [3:0] key_row_n, key_col_n, kidx;
   logic [15:0] base, stored;
   okd_disp_type disp;
   okd_cmd_type cmd;
   int bad_count = 0;
   int n_compared = 0;
   logic s_stop, s_panic, s_pmsg, s_auto, s_commit, s_blank;

   always #50 hclk = ~hclk;

   okd_panel #(.ITEMS(ITEMS), .DEB_CYC(4), .HOLD_CYC(150), .REP_CYC(10), .COARSE_CYC(300),
      .REFRESH_CYC(100), .WARN_CYC(400), .PANIC_CYC(80), .BLANK_CYC(10), .NACK_CYC(300),
      .BLINK_CYC(20)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .key_row_n(key_row_n),
      .key_col_n(key_col_n), .disp(disp), .disp_refresh(disp_refresh), .alarm_led(alarm_led),
      .diag_latched(diag), .manual_override(ovr), .chiller_stopped(stopped), .set_ack(ack),
      .set_value_in(stored), .cmd(cmd));

   okd_far_model far (.hclk(hclk), .hresetn(hresetn), .key_row_n(key_row_n),
      .key_col_n(key_col_n), .down(kdown), .idx(kidx), .cmd(cmd), .base(base),
      .set_value_in(stored));

   // Latch one-cycle pulses between checks.
   always @(posedge hclk) begin
      if (cmd.stop) s_stop <= 1'b1;
      if (cmd.panic) s_panic <= 1'b1;
      if (disp.screen == OKD_SCR_PANIC) s_pmsg <= 1'b1;
      if (cmd.auto_run) s_auto <= 1'b1;
      if (cmd.commit) s_commit <= 1'b1;
      if (disp.blank) s_blank <= 1'b1;
   end

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Clear off the latching edge.
   task automatic clr();
      @(negedge hclk);
      {s_stop, s_panic, s_pmsg, s_auto, s_commit, s_blank} = 6'h0;
      @(posedge hclk);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int w;
      {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 24'h0, a, wr, 3'h2};
      for (int t = 0; t < 2; t++) begin
         w = 0;
         do begin
            @(posedge hclk);
            w++;
         end while (hreadyout !== 1'b1 && w < 50);
         if (w >= 50) begin
            bad_count++;
            conclude();
         end
         if (t == 0) {htrans, hsel, hwdata} <= {2'h0, 1'b0, wd};
      end
      rd = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      check(v, exp);
   endtask

   task automatic press(input logic [3:0] k, input int hold);
      {kidx, kdown} <= {k, 1'b1};
      repeat (hold) @(posedge hclk);
      kdown <= 1'b0;
      repeat (100) @(posedge hclk);
   endtask

   task automatic see(input okd_screen_type s, input logic [2:0] g, input logic [3:0] i);
      check(32'({disp.screen, disp.group, disp.item}), 32'({s, g, i}));
   endtask

   initial begin
      logic [31:0] v;
      logic [15:0] r;
      logic [3:0] it;
      int n;
      {hsel, hwrite, htrans, hsize, haddr, hwdata, kdown, diag, ovr, stopped, ack, kidx, base} <= '0;
      void'($urandom(32'he2fa));
      clr();
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(8'h00, 32'h1);
      bus(1'b1, 8'h10, 32'hffff_ffff, v);
      rd_chk(8'h10, 32'h0);
      press(4'h4, 80);
      see(OKD_SCR_HEADER, 3'h4, 4'h0);
      bus(1'b1, 8'h00, 32'h0, v);
      rd_chk(8'h00, 32'h0);
      press(4'h4, 80);
      see(OKD_SCR_ITEM, 3'h4, 4'h1);
      it = 4'h1;
      for (n = 0; n < 6; n++) begin
         press(n < 4 ? 4'hc : 4'h8, 80);
         if (n < 4) it = (it == ITEMS) ? 4'h1 : it + 4'h1;
         else it = (it == 4'h1) ? 4'(ITEMS) : it - 4'h1;
         see(OKD_SCR_ITEM, 3'h4, it);
      end
      r = 16'($urandom_range(32'h7000, 32'h0100));
      base <= r;
      press(4'h9, 80);
      check(32'({disp.pending, disp.value}), 32'({1'b1, r + 16'h1}));
      press(4'hd, 80);
      press(4'hd, 80);
      check(32'(disp.value), 32'(r - 16'h1));
      press(4'he, 80);
      check(32'({disp.pending, disp.value}), 32'({1'b0, r}));
      press(4'h9, 80);
      clr();
      press(4'ha, 80);
      check(32'({s_commit, s_blank, cmd.group, cmd.item, cmd.value}),
         32'({2'b11, 3'h4, it, r + 16'h1}));
      check(32'(disp.value), 32'(r + 16'h1));
      repeat (250) @(posedge hclk);
      bus(1'b0, 8'h04, 32'h0, v);
      check(32'(v[5]), 32'h1);
      press(4'h9, 500);
      n = int'(disp.value) - int'(r + 16'h1);
      check(32'(n >= 100 && n <= 400), 32'h1);
      press(4'he, 80);
      ovr <= 1'b1;
      repeat (5) @(posedge hclk);
      for (n = 0; n < 30; n++) begin
         @(posedge hclk);
         check(32'(alarm_led), 32'h1);
      end
      diag <= 1'b1;
      n = 0;
      repeat (100) begin
         @(posedge hclk);
         if ($isunknown(alarm_led) == 0 && alarm_led != v[0]) n++;
         v[0] = alarm_led;
      end
      check(32'(n >= 3), 32'h1);
      ovr <= 1'b0;
      diag <= 1'b0;
      clr();
      press(4'hf, 80);
      check(32'(s_stop), 32'h1);
      see(OKD_SCR_STOP_WARN, 3'h1, 4'h1);
      repeat (400) @(posedge hclk);
      see(OKD_SCR_ITEM, 3'h1, 4'h1);
      check(32'(s_panic), 32'h0);
      clr();
      press(4'hf, 80);
      press(4'hf, 80);
      check(32'({s_panic, s_pmsg}), 32'h3);
      see(OKD_SCR_ITEM, 3'h1, 4'h1);
      stopped <= 1'b1;
      press(4'h5, 80);
      clr();
      press(4'hb, 80);
      check(32'(s_auto), 32'h1);
      see(OKD_SCR_ITEM, 3'h1, 4'h1);
      stopped <= 1'b0;
      clr();
      press(4'hb, 80);
      check(32'(s_auto), 32'h0);
      conclude();
   end
endmodule // okd_panel_tb

bind okd_panel okd_panel_props #(.BLINK_CYC(BLINK_CYC)) u_props (.hclk(hclk), .hresetn(hresetn),
   .key_row_n(key_row_n), .disp(disp), .disp_refresh(disp_refresh), .alarm_led(alarm_led),
   .diag_latched(diag_latched), .manual_override(manual_override), .cmd(cmd));
